//--- common/usb_dma_pkg.sv
// constants, field positions and state codes for the usb endpoint dma channel
// assumes a 32-bit byte-addressed system bus and a word-wide endpoint port
package usb_dma_pkg;

    // control word layout
    localparam int CTL_ENABLE      = 0;
    localparam int CTL_LOAD_NEXT   = 1;
    localparam int CTL_CLOSE_SHORT = 2;
    localparam int CTL_RELEASE     = 3;
    localparam int CTL_COUNT_LSB   = 16;
    localparam int COUNT_W         = 16;

    // status word layout
    localparam int ST_ENABLED = 0;
    localparam int ST_ACTIVE  = 1;
    localparam int ST_PENDING = 3;
    localparam int ST_EOT     = 4;
    localparam int ST_EOB     = 5;
    localparam int ST_DESCLD  = 6;

    // sticky flag indices
    localparam int FLAG_EOT    = 0;
    localparam int FLAG_EOB    = 1;
    localparam int FLAG_DESCLD = 2;
    localparam int NUM_FLAGS   = 3;

    // reset values
    localparam logic [31:0] CONTROL_RESET   = 32'h00000000;
    localparam logic [31:0] ADDR_RESET      = 32'h00000000;
    localparam logic [31:0] NEXT_DESC_RESET = 32'h00000000;

    // descriptor layout in memory
    localparam logic [31:0] DESC_NEXT_OFS = 32'h00000000;
    localparam logic [31:0] DESC_BUF_OFS  = 32'h00000004;
    localparam logic [31:0] DESC_CTL_OFS  = 32'h00000008;
    localparam logic [1:0]  DESC_IDX_NEXT = 2'h0;
    localparam logic [1:0]  DESC_IDX_BUF  = 2'h1;
    localparam logic [1:0]  DESC_IDX_CTL  = 2'h2;
    localparam logic [31:0] WORD_BYTES    = 32'h00000004;

    // burst limits
    localparam int MAX_BURST_BEATS = 256;
    localparam int BULK_LOCK_WORDS = 128;
    localparam int ISO_LOCK_WORDS  = 256;
    localparam int BOUNDARY_BYTES  = 1024;
    localparam int BOUNDARY_BITS   = $clog2(BOUNDARY_BYTES);

    // latencies in clock cycles
    localparam logic [2:0] STATUS_LAG_CYCLES = 3'h3;
    localparam logic [2:0] FETCH_LAG_CYCLES  = 3'h2;

    typedef enum logic [2:0] {
        S_IDLE     = 3'b000,
        S_WAIT_PKT = 3'b001,
        S_XFER     = 3'b010,
        S_CLOSE    = 3'b011,
        S_PEND     = 3'b100,
        S_LAG      = 3'b101,
        S_FETCH    = 3'b110
    } chan_state_e;

endpackage

//--- common/burst_if.sv
// link between the channel sequencer and its burst controller
// assumes both ends sit on the same clock
`timescale 1ns/1ns
interface burst_if;
    import usb_dma_pkg::*;
    logic              beat_done;
    logic [31:0]       addr;
    logic              granted;
    logic              restart;
    logic              is_iso;
    logic [8:0]        ep_words;
    logic [COUNT_W-2:0] words_left;
    logic              data_phase;
    logic              first_beat;
    logic              locked;

    modport chan (
        output beat_done, addr, granted, restart, is_iso, ep_words,
        output words_left, data_phase,
        input  first_beat, locked
    );
    modport ctrl (
        input  beat_done, addr, granted, restart, is_iso, ep_words,
        input  words_left, data_phase,
        output first_beat, locked
    );
endinterface

//--- rtl/flag_bank.sv
// sticky event flags, hardware set wins over software clear
// assumes set and clear are one-cycle pulses on clk
`timescale 1ns/1ns
module flag_bank #(
    parameter int N = 3
) (
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire logic [N-1:0] set,
    input  wire logic [N-1:0] clr,
    output logic      [N-1:0] flags
);
    for (genvar i = 0; i < N; i++) begin : g_flag
        always_ff @(posedge clk) begin
            if (reset)
                flags[i] <= 1'b0;
            else if (set[i])
                flags[i] <= 1'b1;
            else if (clr[i])
                flags[i] <= 1'b0;
        end
    end
endmodule

//--- rtl/burst_ctrl.sv
// burst framing and lock window for the channel's bus master
// assumes beat_done marks one accepted word beat at address addr
`timescale 1ns/1ns
module burst_ctrl
    import usb_dma_pkg::*;
(
    input  wire logic clk,
    input  wire logic reset,
    burst_if.ctrl     bi
);
    logic                in_burst;
    logic [8:0]          beats;
    logic [8:0]          lock_beats;
    logic [COUNT_W-2:0]  lock_len;

    wire [8:0] type_cap = bi.is_iso ? 9'(ISO_LOCK_WORDS)
                                    : 9'(BULK_LOCK_WORDS);
    wire [8:0] size_cap = (bi.ep_words < type_cap) ? bi.ep_words : type_cap;
    wire [COUNT_W-2:0] cap_w = (COUNT_W-1)'(size_cap);
    wire [COUNT_W-2:0] lock_limit = (bi.words_left < cap_w) ? bi.words_left
                                                            : cap_w;
    // next word would start a new 1 kbyte page
    wire at_boundary = &bi.addr[BOUNDARY_BITS-1:2];
    wire last_beat   = at_boundary || (beats == 9'(MAX_BURST_BEATS - 1));
    wire end_burst   = !bi.granted || bi.restart
                       || (bi.beat_done && last_beat);

    always_ff @(posedge clk) begin
        if (reset) begin
            in_burst <= 1'b0;
            beats    <= 9'h000;
        end else if (end_burst) begin
            in_burst <= 1'b0;
            beats    <= 9'h000;
        end else if (bi.beat_done) begin
            in_burst <= 1'b1;
            beats    <= beats + 9'h001;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            lock_beats <= 9'h000;
            lock_len   <= '0;
        end else if (bi.restart) begin
            lock_beats <= 9'h000;
            lock_len   <= lock_limit;
        end else if (bi.beat_done && bi.locked) begin
            lock_beats <= lock_beats + 9'h001;
        end
    end

    assign bi.first_beat = !in_burst;
    assign bi.locked     = bi.data_phase && bi.granted
                           && ((COUNT_W-1)'(lock_beats) < lock_len);
endmodule

//--- rtl/usb_endpoint_dma_channel.sv
// one usb endpoint dma channel: endpoint bank <-> system memory
// assumes endpoint and bus signals are synchronous to clk; software
// register access arrives as write strobes with a shared data word
`timescale 1ns/1ns
module usb_endpoint_dma_channel
    import usb_dma_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 reset,
    // software side
    input  wire logic                 sw_next_desc_wr,
    input  wire logic                 sw_buffer_addr_wr,
    input  wire logic                 sw_control_wr,
    input  wire logic [31:0]          sw_wdata,
    input  wire logic [NUM_FLAGS-1:0] sw_flag_clr,
    output logic      [31:0]          chan_next_desc_addr,
    output logic      [31:0]          chan_buffer_addr,
    output logic      [31:0]          chan_control,
    output logic      [31:0]          chan_status,
    output logic      [NUM_FLAGS-1:0] irq_sources,
    // endpoint side
    input  wire logic                 ep_is_in,
    input  wire logic                 ep_is_iso,
    input  wire logic [10:0]          endpoint_size,
    input  wire logic                 ep_packet_ready,
    input  wire logic                 ep_short_packet,
    input  wire logic                 ep_rd_valid,
    input  wire logic [31:0]          ep_rd_data,
    output logic                      ep_rd_pop,
    input  wire logic                 ep_wr_ready,
    output logic                      ep_wr_valid,
    output logic      [31:0]          ep_wr_data,
    output logic                      ep_release,
    // system bus master
    output logic                      bus_req,
    input  wire logic                 bus_gnt,
    output logic                      bus_trans_valid,
    output logic                      bus_first,
    output logic                      bus_lock,
    output logic      [31:0]          bus_addr,
    output logic                      bus_write,
    output logic      [31:0]          bus_wdata,
    input  wire logic [31:0]          bus_rdata,
    input  wire logic                 bus_ready
);
    chan_state_e state, next_state;
    logic [31:0] control, next_control;
    logic [31:0] next_desc, next_next_desc;
    logic [31:0] buffer_addr, next_buffer_addr;
    logic [31:0] fetch_addr, next_fetch_addr;
    logic [1:0]  fetch_idx, next_fetch_idx;
    logic [2:0]  lag, next_lag;
    logic        enabled, next_enabled;
    logic        active, next_active;
    logic        pending, next_pending;
    logic        dir_in, next_dir_in;
    logic        release_q, next_release;
    logic        buf_full;
    logic [31:0] buf_data;
    logic        restart;
    logic [NUM_FLAGS-1:0] flag_set;
    logic [NUM_FLAGS-1:0] flags;

    burst_if bi ();

    // decode of the current situation
    wire in_xfer  = (state == S_XFER);
    wire fetching = (state == S_FETCH);
    wire [COUNT_W-1:0] count = control[CTL_COUNT_LSB +: COUNT_W];
    wire count_zero = (count == '0);
    wire [COUNT_W-1:0] count_dec = (count < COUNT_W'(4)) ? '0
                                   : count - COUNT_W'(4);
    wire in_wants  = dir_in && !buf_full && !count_zero && ep_packet_ready;
    wire out_wants = !dir_in && buf_full;
    wire beat_done = bus_trans_valid && bus_ready;
    wire out_fill  = in_xfer && !dir_in && ep_rd_valid && !buf_full
                     && !count_zero;
    wire in_fill   = in_xfer && dir_in && beat_done;
    wire in_drain  = ep_wr_valid && ep_wr_ready;
    wire word_in   = out_fill || in_fill;
    wire buffer_done = count_zero && !buf_full;
    wire ep_empty  = !ep_packet_ready && !buf_full;
    wire short_close = ep_empty && control[CTL_CLOSE_SHORT]
                       && ep_short_packet;
    wire fetch_last = fetching && beat_done && (fetch_idx == DESC_IDX_CTL);
    wire load_ctrl = fetch_last || ((state == S_IDLE) && sw_control_wr);
    wire [31:0] new_ctrl = fetch_last ? bus_rdata : sw_wdata;
    wire [31:0] fetch_base = next_desc + DESC_NEXT_OFS;

    // bus master
    assign bus_req = (in_xfer && (in_wants || out_wants)) || fetching;
    assign bus_trans_valid = bus_req && bus_gnt;
    assign bus_write = in_xfer && !dir_in;
    assign bus_addr  = fetching ? fetch_addr : buffer_addr;
    assign bus_wdata = buf_data;
    assign bus_first = bi.first_beat;
    assign bus_lock  = bi.locked;

    // endpoint port
    assign ep_rd_pop   = out_fill;
    assign ep_wr_valid = in_xfer && dir_in && buf_full;
    assign ep_wr_data  = buf_data;
    assign ep_release  = release_q;

    assign bi.beat_done  = beat_done;
    assign bi.addr       = bus_addr;
    assign bi.granted    = bus_gnt;
    assign bi.restart    = restart;
    assign bi.is_iso     = ep_is_iso;
    assign bi.ep_words   = endpoint_size[10:2];
    assign bi.words_left = {1'b0, count[COUNT_W-1:2]}
                           + (COUNT_W-1)'(|count[1:0]);
    assign bi.data_phase = in_xfer;

    burst_ctrl u_burst (
        .clk   (clk),
        .reset (reset),
        .bi    (bi)
    );

    assign flag_set[FLAG_EOT]    = in_xfer && !buffer_done && short_close;
    assign flag_set[FLAG_EOB]    = in_xfer && buffer_done;
    assign flag_set[FLAG_DESCLD] = fetch_last;

    flag_bank #(
        .N (NUM_FLAGS)
    ) u_flags (
        .clk   (clk),
        .reset (reset),
        .set   (flag_set),
        .clr   (sw_flag_clr),
        .flags (flags)
    );

    assign irq_sources = flags;

    always_comb begin
        chan_status             = 32'h00000000;
        chan_status[ST_ENABLED] = enabled;
        chan_status[ST_ACTIVE]  = active;
        chan_status[ST_PENDING] = pending;
        chan_status[ST_EOT]     = flags[FLAG_EOT];
        chan_status[ST_EOB]     = flags[FLAG_EOB];
        chan_status[ST_DESCLD]  = flags[FLAG_DESCLD];
    end

    assign chan_next_desc_addr = next_desc;
    assign chan_buffer_addr    = buffer_addr;
    assign chan_control        = control;

    always_comb begin
        next_state       = state;
        next_control     = control;
        next_next_desc   = next_desc;
        next_buffer_addr = buffer_addr;
        next_fetch_addr  = fetch_addr;
        next_fetch_idx   = fetch_idx;
        next_lag         = lag;
        next_enabled     = enabled;
        next_active      = active;
        next_pending     = pending;
        next_dir_in      = dir_in;
        next_release     = 1'b0;
        restart          = 1'b0;
        if (sw_next_desc_wr)
            next_next_desc = sw_wdata;
        if (sw_buffer_addr_wr)
            next_buffer_addr = sw_wdata;
        if (in_xfer && beat_done)
            next_buffer_addr = buffer_addr + WORD_BYTES;
        if (word_in)
            next_control[CTL_COUNT_LSB +: COUNT_W] = count_dec;
        unique case (state)
            S_IDLE: begin
                next_state = S_IDLE;
            end
            S_WAIT_PKT: begin
                if (ep_packet_ready) begin
                    next_active = 1'b1;
                    restart     = 1'b1;
                    next_state  = S_XFER;
                end
            end
            S_XFER: begin
                if (buffer_done || short_close) begin
                    next_control[CTL_ENABLE] = 1'b0;
                    next_active  = 1'b0;
                    next_lag     = STATUS_LAG_CYCLES;
                    next_release = buffer_done && control[CTL_RELEASE]
                                   && !dir_in;
                    next_state   = S_CLOSE;
                end else if (ep_empty) begin
                    next_active = 1'b0;
                    next_state  = S_WAIT_PKT;
                end
            end
            S_CLOSE: begin
                if (lag == 3'h0) begin
                    next_enabled = 1'b0;
                    // load-next bit still set: chain goes on
                    if (control[CTL_LOAD_NEXT]) begin
                        next_fetch_addr = fetch_base;
                        next_fetch_idx  = DESC_IDX_NEXT;
                        next_state      = S_FETCH;
                    end else begin
                        next_state = S_IDLE;
                    end
                end else begin
                    next_lag = lag - 3'h1;
                end
            end
            S_PEND: begin
                if (ep_packet_ready) begin
                    next_active  = 1'b1;
                    next_pending = 1'b0;
                    next_lag     = FETCH_LAG_CYCLES;
                    next_state   = S_LAG;
                end
            end
            S_LAG: begin
                if (lag == 3'h0) begin
                    next_fetch_addr = fetch_base;
                    next_fetch_idx  = DESC_IDX_NEXT;
                    next_state      = S_FETCH;
                end else begin
                    next_lag = lag - 3'h1;
                end
            end
            S_FETCH: begin
                if (beat_done) begin
                    next_fetch_addr = fetch_addr + WORD_BYTES;
                    next_fetch_idx  = fetch_idx + 2'h1;
                    if (fetch_idx == DESC_IDX_NEXT)
                        next_next_desc = bus_rdata;
                    if (fetch_idx == DESC_IDX_BUF)
                        next_buffer_addr = bus_rdata;
                end
            end
            default: begin
                next_state = S_IDLE;
            end
        endcase
        // a control word from software or from a descriptor selects mode
        if (load_ctrl) begin
            next_control = new_ctrl;
            next_dir_in  = ep_is_in;
            next_enabled = new_ctrl[CTL_ENABLE];
            next_pending = !new_ctrl[CTL_ENABLE]
                           && new_ctrl[CTL_LOAD_NEXT];
            if (new_ctrl[CTL_ENABLE])
                next_state = S_WAIT_PKT;
            else if (new_ctrl[CTL_LOAD_NEXT])
                next_state = S_PEND;
            else
                next_state = S_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state       <= S_IDLE;
            control     <= CONTROL_RESET;
            next_desc   <= NEXT_DESC_RESET;
            buffer_addr <= ADDR_RESET;
            fetch_addr  <= ADDR_RESET;
        end else begin
            state       <= next_state;
            control     <= next_control;
            next_desc   <= next_next_desc;
            buffer_addr <= next_buffer_addr;
            fetch_addr  <= next_fetch_addr;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            fetch_idx <= DESC_IDX_NEXT;
            lag       <= 3'h0;
            enabled   <= 1'b0;
            active    <= 1'b0;
            pending   <= 1'b0;
            dir_in    <= 1'b0;
            release_q <= 1'b0;
        end else begin
            fetch_idx <= next_fetch_idx;
            lag       <= next_lag;
            enabled   <= next_enabled;
            active    <= next_active;
            pending   <= next_pending;
            dir_in    <= next_dir_in;
            release_q <= next_release;
        end
    end

    // one-word staging register between endpoint and bus
    always_ff @(posedge clk) begin
        if (reset) begin
            buf_full <= 1'b0;
            buf_data <= 32'h00000000;
        end else if (out_fill) begin
            buf_full <= 1'b1;
            buf_data <= ep_rd_data;
        end else if (in_fill) begin
            buf_full <= 1'b1;
            buf_data <= bus_rdata;
        end else if ((in_xfer && !dir_in && beat_done) || in_drain) begin
            buf_full <= 1'b0;
        end
    end
endmodule

//--- bench/usb_dma_props.sv
// concurrent checks on the dma channel top ports
// assumes a bind from the bench top, one clock
`timescale 1ns/1ns
module usb_dma_props
    import usb_dma_pkg::*;
(
    input wire logic        clk,
    input wire logic        reset,
    input wire logic [31:0] chan_control,
    input wire logic [31:0] chan_status,
    input wire logic [31:0] chan_buffer_addr,
    input wire logic [2:0]  irq_sources,
    input wire logic        ep_is_in,
    input wire logic        ep_rd_valid,
    input wire logic        ep_rd_pop,
    input wire logic        bus_req,
    input wire logic        bus_gnt,
    input wire logic        bus_trans_valid,
    input wire logic        bus_first,
    input wire logic [31:0] bus_addr,
    input wire logic        bus_write,
    input wire logic        bus_ready
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    wire beat = bus_trans_valid && bus_ready;
    sequence pop_legal;
        ep_rd_valid && chan_status[ST_ACTIVE]
            && chan_control[31:16] != 16'h0000;
    endsequence
    sequence status_drops;
        ##[1:6] !chan_status[ST_ENABLED];
    endsequence
    a_enable_status: assert property (
        $rose(chan_control[CTL_ENABLE]) |=> chan_status[ST_ENABLED])
        else $error("enable not reported");
    a_enable_drops: assert property (
        $fell(chan_control[CTL_ENABLE]) |-> status_drops)
        else $error("enabled stuck");
    a_pop_spacing: assert property (
        ep_rd_pop |-> pop_legal ##1 !ep_rd_pop)
        else $error("illegal pop");
    a_addr_step: assert property (
        beat && bus_write |=>
            chan_buffer_addr == $past(chan_buffer_addr) + 32'h4)
        else $error("address step");
    a_beat_addr: assert property (
        beat && bus_write |-> bus_addr == chan_buffer_addr)
        else $error("beat address");
    a_grant_only: assert property (
        bus_trans_valid |-> bus_req && bus_gnt)
        else $error("no grant");
    a_kb_boundary: assert property (
        beat && bus_addr[9:2] == 8'hFF |=> !bus_trans_valid || bus_first)
        else $error("1k crossing");
    a_addr_held: assert property (
        bus_trans_valid && !bus_ready |=> !bus_trans_valid || $stable(bus_addr))
        else $error("address moved");
    a_in_no_write: assert property (
        bus_trans_valid && ep_is_in |-> !bus_write)
        else $error("write on in");
    a_pend_off: assert property (
        chan_status[ST_PENDING] |-> !chan_status[ST_ENABLED])
        else $error("enabled while pending");
    a_irq_flags: assert property (
        irq_sources == {chan_status[ST_DESCLD], chan_status[ST_EOB],
                        chan_status[ST_EOT]})
        else $error("irq mismatch");
endmodule

//--- bench/usb_dma_partner.sv
// memory slave and endpoint bank model for the dma channel
// assumes the bench fills mem and pkt by hierarchy
`timescale 1ns/1ns
module usb_dma_partner (
    input  wire logic        clk,
    input  wire logic        slow,
    input  wire logic        in_mode,
    input  wire logic        bus_req,
    input  wire logic        bus_trans_valid,
    input  wire logic [31:0] bus_addr,
    input  wire logic        bus_write,
    input  wire logic [31:0] bus_wdata,
    output logic             bus_gnt,
    output logic             bus_ready,
    output logic      [31:0] bus_rdata,
    input  wire logic        ep_rd_pop,
    input  wire logic        ep_release,
    output logic             ep_rd_valid,
    output logic      [31:0] ep_rd_data,
    output logic             ep_packet_ready,
    input  wire logic        ep_wr_valid,
    input  wire logic [31:0] ep_wr_data,
    output logic             ep_wr_ready
);
    logic [31:0] mem [0:255];
    logic [31:0] pkt [0:7];
    logic [31:0] in_w [0:7];
    int          pkt_n, pkt_i, in_n;
    logic        tick = 1'b0;
    wire  [31:0] word = mem[bus_addr[9:2]];
    wire  [31:0] head = pkt[pkt_i[2:0]];
    assign bus_gnt = bus_req;
    assign bus_ready = bus_trans_valid && (!slow || tick);
    // junk outside an accepted beat
    assign bus_rdata = bus_ready ? word : ~word;
    assign ep_rd_valid = pkt_i < pkt_n;
    assign ep_rd_data = ep_rd_valid ? head : ~head;
    assign ep_packet_ready = ep_rd_valid || in_mode;
    assign ep_wr_ready = !slow || tick;
    always @(posedge clk) begin
        tick <= !tick;
        if (bus_ready && bus_write)
            mem[bus_addr[9:2]] <= bus_wdata;
        // a released bank drops any residue
        if (ep_release)
            pkt_i <= pkt_n;
        else if (ep_rd_pop)
            pkt_i <= pkt_i + 1;
        if (ep_wr_valid && ep_wr_ready) begin
            in_w[in_n[2:0]] <= ep_wr_data;
            in_n <= in_n + 1;
        end
    end
endmodule

//--- bench/usb_endpoint_dma_channel_test.sv
// self-checking bench for the usb endpoint dma channel
// assumes partner and checker files beside it
`timescale 1ns/1ns
module usb_endpoint_dma_channel_test;
    import usb_dma_pkg::*;
    logic        clk, reset, ep_is_in, ep_short_packet, slow;
    logic        sw_next_desc_wr, sw_buffer_addr_wr, sw_control_wr;
    logic [31:0] sw_wdata, chan_next_desc_addr, chan_buffer_addr;
    logic [31:0] chan_control, chan_status, ep_rd_data, ep_wr_data;
    logic [31:0] bus_addr, bus_wdata, bus_rdata;
    logic [2:0]  sw_flag_clr, irq_sources;
    logic        ep_packet_ready, ep_rd_valid, ep_rd_pop, ep_wr_ready;
    logic        ep_wr_valid, ep_release, bus_req, bus_gnt, bus_ready;
    logic        bus_trans_valid, bus_first, bus_lock, bus_write;
    int          fails, compares, rel_n;
    usb_endpoint_dma_channel uut (
        .clk, .reset, .sw_next_desc_wr, .sw_buffer_addr_wr, .sw_control_wr,
        .sw_wdata, .sw_flag_clr, .chan_next_desc_addr, .chan_buffer_addr,
        .chan_control, .chan_status, .irq_sources, .ep_is_in,
        .ep_is_iso(1'b0), .endpoint_size(11'h040), .ep_packet_ready,
        .ep_short_packet, .ep_rd_valid, .ep_rd_data, .ep_rd_pop,
        .ep_wr_ready, .ep_wr_valid, .ep_wr_data, .ep_release, .bus_req,
        .bus_gnt, .bus_trans_valid, .bus_first, .bus_lock, .bus_addr,
        .bus_write, .bus_wdata, .bus_rdata, .bus_ready
    );
    usb_dma_partner pm (
        .clk, .slow, .in_mode(ep_is_in), .bus_req, .bus_trans_valid,
        .bus_addr, .bus_write, .bus_wdata, .bus_gnt, .bus_ready,
        .bus_rdata, .ep_rd_pop, .ep_release, .ep_rd_valid, .ep_rd_data,
        .ep_packet_ready, .ep_wr_valid, .ep_wr_data, .ep_wr_ready
    );
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(logic [2:0] sel, logic [31:0] d);
        @(posedge clk);
        {sw_next_desc_wr, sw_buffer_addr_wr, sw_control_wr} <= sel;
        sw_wdata <= d;
        @(posedge clk);
        {sw_next_desc_wr, sw_buffer_addr_wr, sw_control_wr} <= 3'h0;
    endtask
    task automatic wait_flag(int idx);
        int n = 0;
        while (irq_sources[idx] !== 1'b1 && n < 300) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("flag", 32'h1, {31'h0, irq_sources[idx]});
    endtask
    task automatic out_pkt(int n, logic [31:0] base);
        @(posedge clk);
        for (int k = 0; k < n; k++)
            pm.pkt[(pm.pkt_n + k) % 8] <= base + k;
        pm.pkt_n <= pm.pkt_n + n;
    endtask
    task automatic settle();
        repeat (6) @(posedge clk);
        #1;
    endtask
    task automatic clr_flags();
        @(posedge clk);
        sw_flag_clr <= 3'h7;
        @(posedge clk);
        sw_flag_clr <= 3'h0;
        settle();
        chk("irq clear", 32'h0, {29'h0, irq_sources});
    endtask
    task automatic s_single();
        wr(3'h2, 32'h0000_0040);
        wr(3'h1, 32'h0008_0009);
        settle();
        chk("enabled", 32'h1, {31'h0, chan_status[ST_ENABLED]});
        out_pkt(3, 32'hA000_0000);
        wait_flag(FLAG_EOB);
        settle();
        chk("ctl en", 32'h0, {31'h0, chan_control[CTL_ENABLE]});
        chk("status", 32'h0, chan_status & 32'h3);
        chk("w0", 32'hA000_0000, pm.mem[16]);
        chk("w1", 32'hA000_0001, pm.mem[17]);
        chk("w2", 32'h0, pm.mem[18]);
        chk("addr", 32'h0000_0048, chan_buffer_addr);
        chk("release", 32'h1, rel_n);
        clr_flags();
    endtask
    task automatic s_short();
        wr(3'h2, 32'h0000_0100);
        wr(3'h1, 32'h0040_0005);
        ep_short_packet <= 1'b1;
        out_pkt(2, 32'hB000_0000);
        wait_flag(FLAG_EOT);
        @(posedge clk);
        ep_short_packet <= 1'b0;
        settle();
        chk("short en", 32'h0, chan_status & 32'h1);
        chk("short w1", 32'hB000_0001, pm.mem[65]);
        clr_flags();
    endtask
    task automatic s_chain();
        pm.mem[128] = 32'h0000_0000;
        pm.mem[129] = 32'h0000_0300;
        pm.mem[130] = 32'h0004_0001;
        wr(3'h4, 32'h0000_0200);
        slow <= 1'b1;
        wr(3'h1, 32'h0000_0002);
        settle();
        chk("pending", 32'h8, chan_status & 32'h9);
        out_pkt(1, 32'hC000_0000);
        wait_flag(FLAG_DESCLD);
        wait_flag(FLAG_EOB);
        settle();
        chk("chain w0", 32'hC000_0000, pm.mem[192]);
        chk("chain end", 32'h0, chan_status & 32'h9);
        @(posedge clk);
        slow <= 1'b0;
        clr_flags();
    endtask
    task automatic s_link();
        wr(3'h4, 32'h0000_0200);
        wr(3'h2, 32'h0000_0380);
        wr(3'h1, 32'h0004_0003);
        out_pkt(1, 32'hD000_0000);
        wait_flag(FLAG_EOB);
        chk("link", 32'h1, {31'h0, chan_control[CTL_LOAD_NEXT]});
        wait_flag(FLAG_DESCLD);
        clr_flags();
        out_pkt(1, 32'hD000_0001);
        wait_flag(FLAG_EOB);
        settle();
        chk("link w0", 32'hD000_0000, pm.mem[224]);
        chk("link w1", 32'hD000_0001, pm.mem[192]);
        clr_flags();
    endtask
    task automatic s_in();
        pm.mem[32] = 32'hE000_0000;
        pm.mem[33] = 32'hE000_0001;
        wr(3'h2, 32'h0000_0080);
        ep_is_in <= 1'b1;
        wr(3'h1, 32'h0008_0001);
        wait_flag(FLAG_EOB);
        settle();
        chk("in w0", 32'hE000_0000, pm.in_w[0]);
        chk("in w1", 32'hE000_0001, pm.in_w[1]);
        chk("in n", 32'h2, pm.in_n);
    endtask
    task automatic complete_run();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk)
        if (ep_release === 1'b1)
            rel_n++;
    initial begin
        reset = 1'b1;
        {sw_next_desc_wr, sw_buffer_addr_wr, sw_control_wr} = 3'h0;
        {ep_is_in, ep_short_packet, slow} = 3'h0;
        sw_wdata = 32'h0;
        sw_flag_clr = 3'h0;
        pm.mem = '{default: 32'h0};
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        #1 chk("reset ctl", CONTROL_RESET, chan_control);
        s_single();
        s_short();
        s_chain();
        s_link();
        s_in();
        complete_run();
    end
    initial begin
        #100000;
        fails++;
        complete_run();
    end
endmodule
bind usb_endpoint_dma_channel usb_dma_props chk_i (.*);
